// file: inc/fwws_pkg.sv
// Package: constants and types for the flash word write sequencer
package fwws_pkg;
   // ********************************
   // Register map (4-bit index)
   // ********************************
   localparam logic [3:0] ADR_PTR_UPPER = 4'h0;
   localparam logic [3:0] ADR_PTR_HIGH = 4'h1;
   localparam logic [3:0] ADR_PTR_LOW = 4'h2;
   localparam logic [3:0] ADR_LATCH = 4'h3;
   localparam logic [3:0] ADR_INT_CTL = 4'h4;
   localparam logic [3:0] ADR_KEY = 4'h5;
   localparam logic [3:0] ADR_CONTROL = 4'h6;
   localparam logic [3:0] ADR_IRQ_STAT = 4'h7;
   localparam logic [3:0] ADR_IRQ_CLR = 4'h8;
   localparam logic [3:0] ADR_IRQ_EN = 4'h9;
   // ********************************
   // Field positions
   // ********************************
   localparam int BIT_WORD_SEL = 5;
   localparam int BIT_FREE = 4;
   localparam int BIT_WR_ERROR = 3;
   localparam int BIT_WR_ENABLE = 2;
   localparam int BIT_WR = 1;
   localparam int BIT_GLOBAL_INT = 7;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   // ********************************
   // Values and reset values
   // ********************************
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_UPPER = 6'h00;
   localparam logic [7:0] CTL_IMPL_MASK = 8'h3e;
   localparam logic [1:0] IRQ_MASK = 2'h3;
   // ********************************
   // Timing
   // ********************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int WRITE_TIME_NS = 2800;
   localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   // ********************************
   // Types
   // ********************************
   typedef enum logic [1:0] {KS_IDLE, KS_FIRST, KS_ARMED} fwws_key_t;
   typedef enum logic {FS_IDLE, FS_PROG} fwws_state_t;
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
   } fwws_req_t;
endpackage

// file: logic/fwws_top.sv
// Flash word write sequencer: registers, unlock, stall and flash drive
// Function
// - Word mode programs one two-byte word
// - Write enable and word select required
// - Interrupts off, then 55h, AAh unlock
// - Write bit after unlock starts programming
// - Processor stalls for whole write time
// - Reset-aborted write leaves error flag set
// - Key register has no storage
// - Control register bit layout, unused zero
// - Pointer split over three byte registers
`timescale 1ns/1ps
module fwws_top
   import fwws_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_en,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [7:0] o_rdata,
   input wire logic i_tbl_wr,
   input wire logic i_tbl_postinc,
   input wire logic i_abort_master_clear,
   input wire logic i_abort_watchdog,
   output logic o_cpu_stall,
   output logic o_flash_prog,
   output fwws_req_t o_flash_req,
   output logic o_irq
);
   // ********************************
   // Reset release
   // ********************************
   logic rst_meta_ff;
   logic rst_sync_ff;

   // Two stages so release is clean against the clock
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   wire rst_n = rst_sync_ff;

   // ********************************
   // State
   // ********************************
   logic [21:0] ptr_ff;
   logic [7:0] latch_ff;
   logic [15:0] hold_ff;
   // Global interrupt enable, the only implemented interrupt control bit
   logic global_int_ff;

   // Control register bits; the free-erase bit is stored and read back only,
   // erase itself is not implemented in this block
   logic word_sel_ff;
   logic free_ff;
   logic err_flag_ff;
   logic wr_enable_ff;
   logic wr_ff;
   fwws_key_t key_ff;
   fwws_state_t st_ff;
   logic [15:0] cnt_ff;
   logic [1:0] irq_stat_ff;
   logic [1:0] irq_en_ff;
   logic [7:0] rdata_ff;
   logic stall_ff;
   logic prog_ff;
   fwws_req_t req_ff;
   logic irq_ff;

   // ********************************
   // Address decode
   // ********************************
   wire wr_upper = i_we && (i_addr == ADR_PTR_UPPER);
   wire wr_high = i_we && (i_addr == ADR_PTR_HIGH);
   wire wr_low = i_we && (i_addr == ADR_PTR_LOW);
   wire wr_latch = i_we && (i_addr == ADR_LATCH);
   wire wr_intctl = i_we && (i_addr == ADR_INT_CTL);
   wire wr_key = i_we && (i_addr == ADR_KEY);
   wire wr_ctl = i_we && (i_addr == ADR_CONTROL);
   wire wr_irqclr = i_we && (i_addr == ADR_IRQ_CLR);
   wire wr_irqen = i_we && (i_addr == ADR_IRQ_EN);

   // Read selection, unmapped and write-only reads return zero
   logic [7:0] rd_mux;
   wire [7:0] ctl_view = {2'b00, word_sel_ff, free_ff, err_flag_ff, wr_enable_ff, wr_ff, 1'b0};
   always_comb begin
      rd_mux = RST_BYTE;
      if (i_addr == ADR_PTR_UPPER) begin
         rd_mux = {2'b00, ptr_ff[21:16]};
      end else if (i_addr == ADR_PTR_HIGH) begin
         rd_mux = ptr_ff[15:8];
      end else if (i_addr == ADR_PTR_LOW) begin
         rd_mux = ptr_ff[7:0];
      end else if (i_addr == ADR_LATCH) begin
         rd_mux = latch_ff;
      end else if (i_addr == ADR_INT_CTL) begin
         rd_mux = {global_int_ff, 7'h00};
      end else if (i_addr == ADR_CONTROL) begin
         rd_mux = ctl_view;
      end else if (i_addr == ADR_IRQ_STAT) begin
         rd_mux = {6'h00, irq_stat_ff};
      end else if (i_addr == ADR_IRQ_EN) begin
         rd_mux = {6'h00, irq_en_ff};
      end
   end

   // ********************************
   // Sequencing terms
   // ********************************
   wire busy = (st_ff == FS_PROG);
   // Both reset events only end a running write here; they do not reset the
   // block itself, so the error flag survives for software to inspect
   wire abort = i_abort_master_clear || i_abort_watchdog;

   // A write of the control register with the write bit set asks for a start
   wire wr_req = wr_ctl && i_wdata[BIT_WR];

   // Start only straight after the unlock pair, with both mode bits set.
   // The mode bits are the stored ones: setting them in the same write that
   // sets the write bit is refused, which keeps a stray write harmless
   wire wr_ok = (key_ff == KS_ARMED) && wr_enable_ff && word_sel_ff;
   wire start = wr_req && wr_ok && !busy;
   wire done = busy && (cnt_ff == RST_COUNT) && !abort;
   wire cut = busy && abort;

   // Unlock tracker: any other bus write breaks the pair
   fwws_key_t nxt_key;
   always_comb begin
      nxt_key = key_ff;
      if (wr_key) begin
         // Unlock only counts with interrupts globally off
         if (global_int_ff) begin
            nxt_key = KS_IDLE;
         end else if (i_wdata == KEY_FIRST) begin
            nxt_key = KS_FIRST;
         end else if ((i_wdata == KEY_SECOND) && (key_ff == KS_FIRST)) begin
            nxt_key = KS_ARMED;
         end else begin
            nxt_key = KS_IDLE;
         end
      end else if (i_we || i_tbl_wr) begin
         nxt_key = KS_IDLE;
      end
   end

   // Pointer next value: bus writes and table post-increment
   logic [21:0] nxt_ptr;
   always_comb begin
      nxt_ptr = ptr_ff;
      if (wr_upper) begin
         nxt_ptr[21:16] = i_wdata[5:0];
      end
      if (wr_high) begin
         nxt_ptr[15:8] = i_wdata;
      end
      if (wr_low) begin
         nxt_ptr[7:0] = i_wdata;
      end
      if (i_tbl_wr && i_tbl_postinc && !busy) begin
         nxt_ptr = ptr_ff + 22'h000001;
      end
   end

   // Holding register lane picked by pointer bit 0, latch value moves in
   logic [15:0] nxt_hold;
   always_comb begin
      nxt_hold = hold_ff;
      if (i_tbl_wr && !busy) begin
         if (ptr_ff[0]) begin
            nxt_hold[15:8] = latch_ff;
         end else begin
            nxt_hold[7:0] = latch_ff;
         end
      end
   end

   // Error flag: hardware set wins over software clear.
   // Writing a one never sets it, so only a real cut write can raise it
   wire nxt_err_flag = cut ? 1'b1 : (wr_ctl ? i_wdata[BIT_WR_ERROR] & err_flag_ff : err_flag_ff);

   // Write bit: software sets through unlock, hardware clears at end
   wire nxt_wr = start ? 1'b1 : ((done || cut) ? 1'b0 : wr_ff);

   // Interrupt status: set wins over the clear
   wire [1:0] irq_ev = {cut, done};
   wire [1:0] irq_clr = wr_irqclr ? i_wdata[1:0] : 2'b00;
   wire [1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
   wire nxt_irq = |(nxt_irq_stat & irq_en_ff);

   // The word address is the even byte under the high-byte pointer
   fwws_req_t nxt_req;
   assign nxt_req.addr = {ptr_ff[21:1], 1'b0};
   assign nxt_req.data = hold_ff;

   // ********************************
   // Register file
   // ********************************
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= {RST_UPPER, RST_BYTE, RST_BYTE};
         latch_ff <= RST_BYTE;
         hold_ff <= {RST_BYTE, RST_BYTE};
         key_ff <= KS_IDLE;
      end else if (i_en) begin
         ptr_ff <= nxt_ptr;
         latch_ff <= wr_latch ? i_wdata : latch_ff;
         hold_ff <= nxt_hold;
         key_ff <= nxt_key;
      end
   end

   // Control bits; mode bits frozen while a write runs
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         global_int_ff <= 1'b0;
         word_sel_ff <= 1'b0;
         free_ff <= 1'b0;
         wr_enable_ff <= 1'b0;
         err_flag_ff <= 1'b0;
         wr_ff <= 1'b0;
      end else if (i_en) begin
         global_int_ff <= wr_intctl ? i_wdata[BIT_GLOBAL_INT] : global_int_ff;
         word_sel_ff <= (wr_ctl && !busy) ? i_wdata[BIT_WORD_SEL] : word_sel_ff;
         free_ff <= (wr_ctl && !busy) ? i_wdata[BIT_FREE] : free_ff;
         wr_enable_ff <= (wr_ctl && !busy) ? i_wdata[BIT_WR_ENABLE] : wr_enable_ff;
         err_flag_ff <= nxt_err_flag;
         wr_ff <= nxt_wr;
      end
   end

   // Interrupt registers
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= 2'b00;
         irq_en_ff <= 2'b00;
         irq_ff <= 1'b0;
      end else if (i_en) begin
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff <= wr_irqen ? (i_wdata[1:0] & IRQ_MASK) : irq_en_ff;
         irq_ff <= nxt_irq;
      end
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= RST_BYTE;
      end else if (i_en) begin
         rdata_ff <= i_re ? rd_mux : RST_BYTE;
      end
   end

   // ********************************
   // Programming sequencer
   // ********************************
   // Counter loaded at start, counts the internal write time down.
   // Loading one less than the cycle count makes the stall last exactly
   // the parameter's number of cycles, with the end state included.
   // The counter is 16 bits wide: the parameter must not exceed 65536.
   // The processor core is expected to hold off all bus traffic while
   // the stall output is high; table writes are dropped in that time
   // and control mode bits cannot change, so a half-done word is never
   // rewritten under the running program cycle.

   fwws_state_t nxt_st;
   logic [15:0] nxt_cnt;
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      case (st_ff)
         FS_IDLE: begin
            if (start) begin
               nxt_st = FS_PROG;
               nxt_cnt = 16'(WRITE_CYC - 1);
            end
         end
         FS_PROG: begin
            // An abort ends the cycle at once, word left suspect
            if (cut || done) begin
               nxt_st = FS_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 16'h0001;
            end
         end
         default: begin
            nxt_st = FS_IDLE;
         end
      endcase
   end

   // Flash drive and stall are flops loaded from the next state, so they change on the same edge as the state
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= FS_IDLE;
         cnt_ff <= RST_COUNT;
         stall_ff <= 1'b0;
         prog_ff <= 1'b0;
         req_ff <= '0;
      end else if (i_en) begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         stall_ff <= (nxt_st == FS_PROG);
         prog_ff <= (nxt_st == FS_PROG);
         req_ff <= start ? nxt_req : req_ff;
      end
   end

   // ********************************
   // Outputs
   // ********************************
   // All outputs come straight from flops, so the core and the flash
   // see glitch-free levels; read data lags a cycle, as does the interrupt after an enable write; the rest load from next-state terms.

   assign o_rdata = rdata_ff;
   assign o_cpu_stall = stall_ff;
   assign o_flash_prog = prog_ff;
   assign o_flash_req = req_ff;
   assign o_irq = irq_ff;
endmodule

// file: bench/fwws_top_asserts.sv
// Port checker for the flash word write sequencer
`timescale 1ns/1ps
module fwws_top_asserts
   import fwws_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_en,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   input wire logic [7:0] o_rdata,
   input wire logic i_tbl_wr,
   input wire logic i_tbl_postinc,
   input wire logic i_abort_master_clear,
   input wire logic i_abort_watchdog,
   input wire logic o_cpu_stall,
   input wire logic o_flash_prog,
   input wire fwws_req_t o_flash_req,
   input wire logic o_irq
);
   // ****
   // Stall length
   // ****
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic abort;
   // Cycles already stalled; assumes the clock enable stays high
   assign nxt_cnt = o_cpu_stall ? cnt_ff + 16'h0001 : 16'h0000;
   assign abort = i_en && (i_abort_master_clear || i_abort_watchdog);
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   // ****
   // Assertions
   // ****
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   a_stall_is_prog: assert property (o_cpu_stall == o_flash_prog)
      else $error("stall and programming differ");
   a_stall_bound: assert property (o_cpu_stall |-> cnt_ff < WRITE_CYC)
      else $error("stall too long");
   a_stall_full: assert property ($fell(o_cpu_stall) |-> $past(abort) || cnt_ff == WRITE_CYC)
      else $error("stall ended early");
   a_abort_stops: assert property (abort && o_cpu_stall |=> !o_cpu_stall)
      else $error("abort did not end write");
   a_start_cause: assert property ($rose(o_cpu_stall) |->
      $past(i_we && i_addr == ADR_CONTROL && i_wdata[BIT_WR])) else $error("start without write bit");
   a_req_held: assert property (o_cpu_stall && $past(o_cpu_stall) |-> $stable(o_flash_req))
      else $error("request moved during write");
   a_req_even: assert property (o_flash_prog |-> !o_flash_req.addr[0])
      else $error("odd word address");
   a_ctl_unused: assert property ($past(i_re && i_addr == ADR_CONTROL) |->
      o_rdata[7:6] == 2'h0 && !o_rdata[0]) else $error("unused control bits set");
   a_key_no_store: assert property ($past(i_re && i_addr == ADR_KEY) |-> o_rdata == 8'h00)
      else $error("key register reads nonzero");
endmodule

// file: bench/fwws_flash_model.sv
// Behavioural program flash that records word programming requests
`timescale 1ns/1ps
module fwws_flash_model
   import fwws_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_prog,
   input wire fwws_req_t i_req,
   output logic [15:0] o_word,
   output logic [21:0] o_addr,
   output logic [7:0] o_writes
);
   logic prog_ff;
   // Starts counted at zero, contents unknown until programmed
   initial begin
      prog_ff = 1'b0;
      o_writes = 8'h00;
   end
   // One word lands per programming pulse, never a whole row
   always @(posedge i_clk_sys) begin
      prog_ff <= i_prog;
      if (i_prog && !prog_ff) begin
         o_word <= i_req.data;
         o_addr <= i_req.addr;
         o_writes <= o_writes + 8'h01;
      end
   end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the flash word write sequencer
`timescale 1ns/1ps
module testbench;
   import fwws_pkg::*;
   localparam int WCYC = 4;
   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_en = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_we = 1'b0;
   logic i_re = 1'b0;
   logic i_tbl_wr = 1'b0;
   logic i_tbl_postinc = 1'b0;
   logic i_abort_master_clear = 1'b0;
   logic i_abort_watchdog = 1'b0;
   logic [7:0] o_rdata;
   logic o_cpu_stall;
   logic o_flash_prog;
   logic o_irq;
   fwws_req_t o_flash_req;
   logic [15:0] fl_word;
   logic [21:0] fl_addr;
   logic [7:0] fl_writes;
   int num_errors = 0;
   int n_tests = 0;
   int n;
   logic [7:0] v;
   // Rows: index, write data, expected read back
   logic [19:0] rows [0:9] = '{20'h0ff3f, 20'h15a5a, 20'h2a5a5, 20'h33c3c, 20'h4ff80,
      20'h55500, 20'h6ff34, 20'h90303, 20'h8ff00, 20'hfff00};
   always #4 i_clk_sys = ~i_clk_sys;
   fwws_top #(.WRITE_CYC(WCYC)) dut (.i_clk_sys, .i_arst_n, .i_en, .i_addr, .i_wdata, .i_we,
      .i_re, .o_rdata, .i_tbl_wr, .i_tbl_postinc, .i_abort_master_clear, .i_abort_watchdog,
      .o_cpu_stall,
      .o_flash_prog, .o_flash_req, .o_irq);
   fwws_flash_model u_flash (.i_clk_sys, .i_prog(o_flash_prog), .i_req(o_flash_req),
      .o_word(fl_word), .o_addr(fl_addr), .o_writes(fl_writes));
   // ****
   // Bus tasks
   // ****
   task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   // Strobe left high so back-to-back writes keep it high between them
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_re <= 1'b0;
      i_we <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      i_we <= 1'b0;
      i_re <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_re <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic tw(input logic p);
      i_we <= 1'b0;
      i_tbl_wr <= 1'b1;
      i_tbl_postinc <= p;
      @(posedge i_clk_sys);
      i_tbl_wr <= 1'b0;
   endtask
   // Mode bits, then the unlock pair, then the write bit
   task automatic go(input logic [7:0] pre, input logic global_interrupt_enable, input logic brk);
      wr(ADR_CONTROL, pre);
      wr(ADR_INT_CTL, {global_interrupt_enable, 7'h00});
      wr(ADR_KEY, KEY_FIRST);
      if (brk) wr(ADR_LATCH, 8'h00);
      wr(ADR_KEY, KEY_SECOND);
      wr(ADR_CONTROL, pre | 8'h02);
      i_we <= 1'b0;
      #1;
   endtask
   // Even address, low byte with increment, high byte without; each address fresh
   task automatic prog(input logic [21:0] a, input logic [7:0] lo, input logic [7:0] hi);
      wr(ADR_PTR_UPPER, {2'h0, a[21:16]});
      wr(ADR_PTR_HIGH, a[15:8]);
      wr(ADR_PTR_LOW, a[7:0]);
      wr(ADR_LATCH, lo);
      tw(1'b1);
      wr(ADR_LATCH, hi);
      tw(1'b0);
      go(8'h24, 1'b0, 1'b0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      for (int a = 0; a < 10; a++) begin
         rd(4'(a), v);
         chk("reset value", 8'h00, v);
      end
      foreach (rows[i]) begin
         wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16], v);
         chk("register", rows[i][7:0], v);
      end
      $display("test registers ended");
      prog(22'h2abcde, 8'h11, 8'h22);
      chk("stall start", 1'b1, o_cpu_stall);
      chk("request", {22'h2abcde, 16'h2211}, o_flash_req);
      n = 0;
      while (o_cpu_stall && n < 100) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      chk("stall cycles", WCYC, n);
      chk("flash word", 16'h2211, fl_word);
      chk("flash addr", 22'h2abcde, fl_addr);
      rd(ADR_CONTROL, v);
      chk("write bit", 8'h24, v);
      wr(ADR_INT_CTL, 8'h80);
      wr(ADR_CONTROL, 8'h00);
      rd(ADR_CONTROL, v);
      chk("mode cleared", 8'h00, v);
      rd(ADR_IRQ_STAT, v);
      chk("done status", 8'h01, v);
      chk("irq", 1'b1, o_irq);
      wr(ADR_IRQ_EN, 8'h00);
      rd(ADR_IRQ_STAT, v);
      chk("masked irq", 1'b0, o_irq);
      wr(ADR_IRQ_CLR, 8'h03);
      wr(ADR_IRQ_EN, 8'h03);
      rd(ADR_IRQ_STAT, v);
      chk("cleared", 8'h00, v);
      $display("test word write ended");
      for (int k = 0; k < 4; k++) begin
         go(k == 1 ? 8'h20 : (k == 3 ? 8'h04 : 8'h24), k == 2, k == 0);
         repeat (2) @(posedge i_clk_sys);
         chk("refused start", 1'b0, o_cpu_stall);
      end
      chk("flash writes", 8'h01, fl_writes);
      $display("test refusals ended");
      for (int k = 0; k < 2; k++) begin
         wr(ADR_IRQ_CLR, 8'h03);
         prog(22'h001000 + 22'(4 * k), 8'h33, 8'h44);
         @(posedge i_clk_sys);
         i_abort_master_clear <= (k == 0);
         i_abort_watchdog <= (k == 1);
         @(posedge i_clk_sys);
         i_abort_master_clear <= 1'b0;
         i_abort_watchdog <= 1'b0;
         #1 chk("stall after abort", 1'b0, o_cpu_stall);
         rd(ADR_CONTROL, v);
         chk("error flag", 8'h2c, v);
         rd(ADR_IRQ_STAT, v);
         chk("error status", 1'b1, v[1]);
      end
      $display("test aborts ended");
      end_of_test();
   end
   // Whole run needs about 125 cycles
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      num_errors++;
      end_of_test();
   end
endmodule
bind fwws_top fwws_top_asserts #(.WRITE_CYC(WRITE_CYC)) u_chk (.i_clk_sys, .i_arst_n, .i_en,
   .i_addr, .i_wdata, .i_we, .i_re, .o_rdata, .i_tbl_wr, .i_tbl_postinc, .i_abort_master_clear,
   .i_abort_watchdog, .o_cpu_stall, .o_flash_prog, .o_flash_req, .o_irq);
